/* pwm_diag_pkg.sv */
// package: constants and carriers for the pwm output diagnostic record
package pwm_diag_pkg;
    localparam int          REC_BYTES          = 20;
    localparam logic [7:0]  REC_FULL_NUM       = 8'h01;
    localparam logic [7:0]  REC_SHORT_NUM      = 8'h00;
    localparam logic [15:0] IDX_FULL           = 16'h2F01;
    localparam logic [15:0] IDX_SHORT          = 16'h2F00;
    localparam logic [15:0] IDX_ECAT           = 16'h5005;
    localparam int          SHORT_BYTES        = 4;
    localparam logic [7:0]  SUB_FIRST          = 8'h02;
    localparam logic [7:0]  SUB_CHFAULT_LAST   = 8'h11;
    localparam logic [7:0]  SUB_TIMESTAMP      = 8'h13;
    localparam int          POS_MODINFO        = 1;
    localparam int          POS_CHTYPE         = 4;
    localparam int          POS_BITS           = 5;
    localparam int          POS_COUNT          = 6;
    localparam int          POS_STAMP          = 16;
    localparam logic [3:0]  MODCLASS_DIGITAL   = 4'hF;
    localparam int          CHINFO_BIT         = 4;
    localparam logic [7:0]  MODINFO_RESET      = 8'h1F;
    localparam logic [6:0]  CHTYPE_DOUT        = 7'h72;
    localparam logic [7:0]  DIAG_BITS_VALUE    = 8'h00;
    localparam logic [7:0]  CHANNEL_COUNT      = 8'h02;
    localparam int          CLK_MHZ            = 100;
    localparam int          US_TICK_CYCLES     = CLK_MHZ;
    localparam int          PERIOD_MIN_NS      = 25000;
    localparam int          TIMEBASE_PS        = 20830;
    localparam int          PERIOD_MIN_COUNTS  = 1200;
    localparam int          PERIOD_MAX_COUNTS  = 8388607;
    localparam logic [31:0] PERIOD_RESET       = 32'h0000_1F40;

    typedef enum logic [1:0] {
        ACC_RECORD = 2'h0,
        ACC_INDEX  = 2'h1,
        ACC_SUBIDX = 2'h2
    } access_kind_t;

    typedef struct packed {
        access_kind_t kind;
        logic [15:0]  sel;
        logic [7:0]   sub;
        logic [4:0]   byte_ix;
    } diag_req_t;

    typedef struct packed {
        logic        ok;
        logic [4:0]  len;
        logic [7:0]  data;
    } diag_rsp_t;
endpackage

/* pwm_output_diagnostic_record.sv */
// pwm output diagnostic record and two-channel pwm generator
`timescale 1ns/1ps

module pwm_output_diagnostic_record
    import pwm_diag_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    input  wire logic [NUM_CH-1:0]  period_wr,
    input  wire logic [31:0]        period_val,
    input  wire logic [NUM_CH-1:0]  pulse_wr,
    input  wire logic [31:0]        pulse_val,
    input  wire logic               diag_req_valid,
    input  wire diag_req_t          diag_req,
    output diag_rsp_t               diag_rsp,
    output logic                    diag_rsp_valid,
    output logic [NUM_CH-1:0]       pwm_out
);
    // one clock period in picoseconds, the step of the time-base accumulator
    localparam int TB_STEP_PS  = 10000;
    // widths of the helper counters
    localparam int US_DIV_W    = 7;
    localparam int TB_ACC_W    = 16;
    // the timestamp fills the record from its position to the end
    localparam int STAMP_BYTES = REC_BYTES - POS_STAMP;

    // the channel-count byte is fixed, so only two channels can be reported
    if (NUM_CH != 2) begin : g_bad_ch
        $error("channel count must be 2");
    end

    // the divider must be able to count one microsecond of clocks
    if (US_TICK_CYCLES > (1 << US_DIV_W)) begin : g_bad_div
        $error("microsecond divider too narrow");
    end

    // the accumulator must hold a whole time-base step plus one clock
    if ((TIMEBASE_PS + TB_STEP_PS) >= (1 << TB_ACC_W)) begin : g_bad_acc
        $error("time-base accumulator too narrow");
    end

    // a clock slower than the time base would skip ticks
    if (TB_STEP_PS > TIMEBASE_PS) begin : g_bad_step
        $error("clock too slow for the pwm time base");
    end

    // byte positions are five bits wide
    if (REC_BYTES > 32) begin : g_bad_rec
        $error("record longer than the byte index can reach");
    end

    logic [31:0]         us_count_q;
    logic [31:0]         us_count_d;
    logic [US_DIV_W-1:0] us_div_q;
    logic [US_DIV_W-1:0] us_div_d;
    logic [31:0]         stamp_q;
    logic [31:0]         stamp_d;
    logic [TB_ACC_W-1:0] tb_acc_q;
    logic [TB_ACC_W-1:0] tb_acc_d;
    logic                tb_tick;
    diag_rsp_t           rsp_q;
    diag_rsp_t           rsp_d;
    logic                rsp_v_q;
    logic                rsp_v_d;
    logic [4:0]          req_len;
    logic [4:0]          req_pos;
    logic                req_hit;

    // length of the object that a request selects; zero for anything unknown
    function automatic logic [4:0] obj_len(input diag_req_t r);
        logic [4:0] n;
        n = 5'h00;
        if (r.kind == ACC_RECORD) begin
            if (r.sel[7:0] == REC_FULL_NUM) begin
                n = 5'(REC_BYTES);
            end else if (r.sel[7:0] == REC_SHORT_NUM) begin
                n = 5'(SHORT_BYTES);
            end
        end else if (r.kind == ACC_INDEX) begin
            if (r.sel == IDX_FULL) begin
                n = 5'(REC_BYTES);
            end else if (r.sel == IDX_SHORT) begin
                n = 5'(SHORT_BYTES);
            end
        end else if (r.kind == ACC_SUBIDX && r.sel == IDX_ECAT) begin
            if (r.sub >= SUB_FIRST && r.sub <= SUB_CHFAULT_LAST) begin
                n = 5'h01;
            end else if (r.sub == SUB_TIMESTAMP) begin
                n = 5'(STAMP_BYTES);
            end
        end
        return n;
    endfunction

    // record position of the byte that a request asks for
    function automatic logic [4:0] obj_pos(input diag_req_t r);
        logic [4:0] p;
        p = r.byte_ix;
        if (r.kind == ACC_SUBIDX) begin
            if (r.sub == SUB_TIMESTAMP) begin
                p = 5'(POS_STAMP) + r.byte_ix;
            end else begin
                p = 5'(r.sub - SUB_FIRST);
            end
        end
        return p;
    endfunction

    function automatic logic [7:0] rec_byte(input logic [4:0] ix, input logic [31:0] st);
        logic [7:0] b;
        b = 8'h00;
        if (ix == 5'(POS_MODINFO)) begin
            b = {3'h0, 1'b1, MODCLASS_DIGITAL};
        end else if (ix == 5'(POS_CHTYPE)) begin
            b = {1'b0, CHTYPE_DOUT};
        end else if (ix == 5'(POS_BITS)) begin
            b = DIAG_BITS_VALUE;
        end else if (ix == 5'(POS_COUNT)) begin
            b = CHANNEL_COUNT;
        end else if (ix >= 5'(POS_STAMP) && ix < 5'(REC_BYTES)) begin
            b = st[8*(ix-5'(POS_STAMP)) +: 8];
        end
        return b;
    endfunction

    // free-running microsecond counter; wraps silently after 2^32 us
    always_comb begin
        us_div_d   = us_div_q + US_DIV_W'(1);
        us_count_d = us_count_q;
        if (us_div_q == US_DIV_W'(US_TICK_CYCLES - 1)) begin
            us_div_d   = '0;
            us_count_d = us_count_q + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            us_count_q <= 32'h0;
            us_div_q   <= '0;
        end else begin
            us_count_q <= us_count_d;
            us_div_q   <= us_div_d;
        end
    end

    // pwm time base; the clock is no multiple of it, so ticks jitter by one clock
    always_comb begin
        tb_acc_d = tb_acc_q + TB_ACC_W'(TB_STEP_PS);
        tb_tick  = 1'b0;
        if ({16'h0, tb_acc_q} + 32'(TB_STEP_PS) >= 32'(TIMEBASE_PS)) begin
            tb_acc_d = TB_ACC_W'({16'h0, tb_acc_q} + 32'(TB_STEP_PS) - 32'(TIMEBASE_PS));
            tb_tick  = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tb_acc_q <= '0;
        end else begin
            tb_acc_q <= tb_acc_d;
        end
    end

    // record access; no interrupt path exists, the record is only answered on request
    always_comb begin
        req_len = obj_len(diag_req);
        req_pos = obj_pos(diag_req);
        req_hit = diag_req_valid && (req_len != 5'h00) && (diag_req.byte_ix < req_len);
        rsp_d   = '0;
        rsp_v_d = diag_req_valid;
        stamp_d = stamp_q;
        // the record is generated whenever any request asks for byte index zero, refused or not
        if (diag_req_valid && diag_req.byte_ix == 5'h00) begin
            stamp_d = us_count_q;
        end
        // refused requests still answer, with ok low and data zero
        if (req_hit) begin
            rsp_d.ok   = 1'b1;
            rsp_d.len  = req_len;
            rsp_d.data = rec_byte(req_pos, stamp_d);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stamp_q <= 32'h0;
            rsp_q   <= '0;
            rsp_v_q <= 1'b0;
        end else begin
            stamp_q <= stamp_d;
            rsp_q   <= rsp_d;
            rsp_v_q <= rsp_v_d;
        end
    end

    // pwm channels, one copy of the same logic each
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [31:0] period_q;
        logic [31:0] period_d;
        logic [31:0] pulse_q;
        logic [31:0] pulse_d;
        logic [31:0] phase_q;
        logic [31:0] phase_d;
        logic        out_q;
        logic        out_d;
        logic        period_ok;

        always_comb begin
            period_ok = (period_val >= 32'(PERIOD_MIN_COUNTS))
                        && (period_val <= 32'(PERIOD_MAX_COUNTS));
            period_d  = period_q;
            pulse_d   = pulse_q;
            phase_d   = phase_q;
            // short periods are dropped and the old period is kept
            if (period_wr[c] && period_ok) begin
                period_d = period_val;
            end
            if (pulse_wr[c]) begin
                pulse_d = pulse_val;
            end
            // a shortened period restarts the phase instead of running to wrap
            if (tb_tick) begin
                if (phase_q + 32'h1 >= period_q) begin
                    phase_d = 32'h0;
                end else begin
                    phase_d = phase_q + 32'h1;
                end
            end
            if (pulse_q >= period_q) begin
                out_d = 1'b1;
            end else begin
                out_d = (phase_q < pulse_q);
            end
        end

        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                period_q <= PERIOD_RESET;
                pulse_q  <= 32'h0;
                phase_q  <= 32'h0;
                out_q    <= 1'b0;
            end else begin
                period_q <= period_d;
                pulse_q  <= pulse_d;
                phase_q  <= phase_d;
                out_q    <= out_d;
            end
        end

        assign pwm_out[c] = out_q;
    end

    assign diag_rsp       = rsp_q;
    assign diag_rsp_valid = rsp_v_q;
endmodule

/* pwm_diag_props.sv */
// checker for diagnostic response timing and contents
`timescale 1ns/1ps
module pwm_diag_props
    import pwm_diag_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      rst_b,
    input  wire logic      diag_req_valid,
    input  wire diag_req_t diag_req,
    input  wire diag_rsp_t diag_rsp,
    input  wire logic      diag_rsp_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire rec = diag_req_valid && diag_req.kind == ACC_RECORD;
    wire idx = diag_req_valid && diag_req.kind == ACC_INDEX;
    wire full_rec = rec && diag_req.sel == {8'h00, REC_FULL_NUM};
    wire short_rec = rec && diag_req.sel == {8'h00, REC_SHORT_NUM};
    property p_answer; diag_req_valid |=> diag_rsp_valid; endproperty
    a_answer: assert property (p_answer) else $error("no response to request");
    property p_quiet; !diag_req_valid |=> !diag_rsp_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("response without request");
    property p_full; full_rec && diag_req.byte_ix < 5'd20 |=> diag_rsp.ok && diag_rsp.len == 5'd20;
    endproperty
    a_full: assert property (p_full) else $error("full record length wrong");
    property p_short; short_rec && diag_req.byte_ix >= 5'd4 |=> !diag_rsp.ok && diag_rsp.data == 8'h00;
    endproperty
    a_short: assert property (p_short) else $error("short record overrun");
    property p_index; idx && diag_req.sel == IDX_FULL && diag_req.byte_ix < 5'd20
        |=> diag_rsp.ok && diag_rsp.len == 5'd20; endproperty
    a_index: assert property (p_index) else $error("full index length wrong");
    property p_modinfo; full_rec && diag_req.byte_ix == 5'd1 |=> diag_rsp.data == 8'h1F; endproperty
    a_modinfo: assert property (p_modinfo) else $error("module info wrong");
    property p_chtype; full_rec && diag_req.byte_ix == 5'd4 |=> diag_rsp.data == 8'h72; endproperty
    a_chtype: assert property (p_chtype) else $error("channel type wrong");
    property p_bits; full_rec && diag_req.byte_ix == 5'd5 |=> diag_rsp.data == 8'h00; endproperty
    a_bits: assert property (p_bits) else $error("diagnostic bit count wrong");
    property p_count; full_rec && diag_req.byte_ix == 5'd6 |=> diag_rsp.data == 8'h02; endproperty
    a_count: assert property (p_count) else $error("channel count wrong");
    property p_rsvd; full_rec && diag_req.byte_ix >= 5'd7 && diag_req.byte_ix < 5'd16
        |=> diag_rsp.data == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");
    property p_stamp; diag_req_valid && diag_req.kind == ACC_SUBIDX && diag_req.sel == IDX_ECAT
        && diag_req.sub == SUB_TIMESTAMP && diag_req.byte_ix < 5'd4 |=> diag_rsp.len == 5'd4;
    endproperty
    a_stamp: assert property (p_stamp) else $error("timestamp length wrong");
endmodule

/* head_unit_model.sv */
// head unit model: parameterises periods, writes pulses, reads the record
`timescale 1ns/1ps
module head_unit_model
    import pwm_diag_pkg::*;
(
    input  wire logic  sys_clk,
    output logic [1:0] period_wr,
    output logic [31:0] period_val,
    output logic [1:0] pulse_wr,
    output logic [31:0] pulse_val,
    output logic       diag_req_valid,
    output diag_req_t  diag_req
);
    initial begin
        {period_wr, pulse_wr, period_val, pulse_val, diag_req_valid} = '0;
        diag_req = '0;
    end
    // caller sits on a rising edge; requests may run back to back
    task automatic ask(access_kind_t k, logic [15:0] s, logic [7:0] sb, logic [4:0] ix);
        diag_req_valid <= 1'b1;
        diag_req <= '{kind: k, sel: s, sub: sb, byte_ix: ix};
        @(posedge sys_clk);
    endtask
    task automatic idle();
        diag_req_valid <= 1'b0;
        @(posedge sys_clk);
    endtask
    // duty is period by parameter plus pulse by output area
    task automatic setv(bit pulse, int ch, logic [31:0] v);
        if (pulse) begin
            pulse_wr <= 2'b01 << ch;
            pulse_val <= v;
        end else begin
            period_wr <= 2'b01 << ch;
            period_val <= v;
        end
        @(posedge sys_clk);
        {period_wr, pulse_wr} <= '0;
        @(posedge sys_clk);
    endtask
endmodule

/* pwm_output_diagnostic_record_tb.sv */
// self-checking bench for the pwm diagnostic record block
`timescale 1ns/1ps
module pwm_output_diagnostic_record_tb
    import pwm_diag_pkg::*;
;
    logic sys_clk = 1'b0, rst_b = 1'b0;
    logic [1:0] period_wr, pulse_wr, pwm_out;
    logic [31:0] period_val, pulse_val;
    logic diag_req_valid, diag_rsp_valid;
    diag_req_t diag_req;
    diag_rsp_t diag_rsp;
    diag_rsp_t exp_q[$], msk_q[$];
    int error_cnt = 0, checks_done = 0, cyc = 0, hi, lo;
    always #5 sys_clk = ~sys_clk;
    pwm_output_diagnostic_record #(.NUM_CH(2)) pwm_output_diagnostic_record_i (.*);
    head_unit_model head_unit_model_i (.*);
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (e !== g) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [7:0] rec_byte(int b);
        case (b)
            1: return 8'h1F;
            4: return 8'h72;
            6: return 8'h02;
            default: return 8'h00; // reserved and bits-per-channel are zero
        endcase
    endfunction
    // note expectation, then ask; timestamp data and refused length are masked
    task automatic req(access_kind_t k, logic [15:0] s, logic [7:0] sb, int ix, int n, bit ts);
        bit ok;
        int p;
        ok = ix < n;
        p = (k == ACC_SUBIDX) ? int'(sb) - 2 : ix;
        exp_q.push_back('{ok: ok, len: 5'(n), data: ok ? rec_byte(ts ? 0 : p) : 8'h00});
        msk_q.push_back('{ok: 1'b1, len: {5{ok}}, data: {8{!(ts && ok)}}});
        head_unit_model_i.ask(k, s, sb, 5'(ix));
    endtask
    always @(posedge sys_clk) begin
        diag_rsp_t e, m;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            end_sim();
        end
        if (diag_rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) chk("spurious response", 32'h0, 32'h1);
            else begin
                e = exp_q.pop_front();
                m = msk_q.pop_front();
                chk("response", 32'(e & m), 32'(diag_rsp & m));
            end
        end
    end
    task automatic watch(int ch, int n);
        {hi, lo} = '0;
        repeat (n) begin
            @(posedge sys_clk);
            if (pwm_out[ch] === 1'b1) hi++;
            else lo++;
        end
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        void'($urandom(32'hA86F7891));
        for (int b = 0; b < 22; b++) begin
            req(ACC_RECORD, 16'h0001, 8'h00, b, 20, b >= POS_STAMP);
            req(ACC_RECORD, 16'h0000, 8'h00, b, 4, 0);
            req(ACC_INDEX, IDX_FULL, 8'h00, b, 20, b >= POS_STAMP);
            req(ACC_INDEX, IDX_SHORT, 8'h00, b, 4, 0);
        end
        req(ACC_RECORD, 16'h0002, 8'h00, 0, 0, 0);
        req(ACC_INDEX, 16'h2F02, 8'h00, 0, 0, 0);
        for (int s = 2; s < 8'h13; s++) req(ACC_SUBIDX, IDX_ECAT, 8'(s), 0, s == 8'h12 ? 0 : 1, 0);
        for (int i = 0; i < 4; i++) req(ACC_SUBIDX, IDX_ECAT, SUB_TIMESTAMP, i, 4, 1);
        repeat (20) begin
            int s;
            s = 2 + $urandom % 16;
            req(ACC_SUBIDX, IDX_ECAT, 8'(s), 0, 1, 0);
        end
        head_unit_model_i.idle();
        repeat (2) @(posedge sys_clk);
        chk("queue left", 32'd0, 32'(exp_q.size()));
        head_unit_model_i.setv(0, 0, 32'd1200);
        head_unit_model_i.setv(1, 0, 32'd1199);
        head_unit_model_i.setv(0, 0, 32'd1150);
        watch(0, 2600);
        chk("short period ignored", 32'd1, 32'(lo > 0 && hi > 0));
        head_unit_model_i.setv(1, 0, 32'd1200);
        repeat (3) @(posedge sys_clk);
        watch(0, 3000);
        chk("pulse at period high", 32'd0, 32'(lo));
        head_unit_model_i.setv(1, 1, 32'd4000);
        watch(1, 17000);
        chk("half duty", 32'd1, 32'(hi > 6000 && lo > 6000));
        end_sim();
    end
endmodule
bind pwm_output_diagnostic_record pwm_diag_props pwm_diag_props_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .diag_req_valid(diag_req_valid),
    .diag_req(diag_req), .diag_rsp(diag_rsp), .diag_rsp_valid(diag_rsp_valid));
